// *** verilog/gpio_port_pkg.sv ***
// Purpose: Shared constants and types for the general-purpose parallel I/O port.
// Assumes: APB byte addresses; every register takes one aligned 32-bit word.
// Notes:   Only the low half-word of each register carries pin bits.
`default_nettype none

package gpio_port_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [15:0] PIN_DIRECTION_OFFSET     = 16'h6180;  // Direction control.
    localparam logic [15:0] PIN_LEVEL_OFFSET         = 16'h6190;  // Sampled pin state.
    localparam logic [15:0] OUTPUT_LATCH_OFFSET      = 16'h61a0;  // Output latch.
    localparam logic [15:0] OPEN_DRAIN_SELECT_OFFSET = 16'h61b0;  // Open-drain select.

    // Alias displacement from each base register, in bytes.
    localparam logic [15:0] CLEAR_ALIAS_OFFSET  = 16'h0004;
    localparam logic [15:0] SET_ALIAS_OFFSET    = 16'h0008;
    localparam logic [15:0] INVERT_ALIAS_OFFSET = 16'h000c;

    // ------------------------------------------------------------------
    // Pin layout and reset values per variant
    // ------------------------------------------------------------------
    localparam int          PIN_COUNT        = 16;       // Width of the pin half-word.
    localparam logic [15:0] LARGE_IMPL_MASK  = 16'hf3cf;  // Pins 15:12, 9:6, 3:0.
    localparam logic [15:0] SMALL_IMPL_MASK  = 16'h03cc;  // Pins 9:6, 3:2.
    localparam logic [15:0] LARGE_DIR_RESET  = 16'hf3cf;  // All implemented pins inputs.
    localparam logic [15:0] SMALL_DIR_RESET  = 16'h03cc;  // All implemented pins inputs.
    localparam logic [15:0] OPEN_DRAIN_RESET = 16'h0000;  // Push-pull everywhere.
    localparam logic [15:0] LATCH_RESET      = 16'h0000;  // Any value is legal here.
    localparam logic [15:0] SAMPLE_RESET     = 16'h0000;  // Any value is legal here.

    // ------------------------------------------------------------------
    // Alias operations, selected by address bits 3:2
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        OP_WRITE  = 2'h0,
        OP_CLEAR  = 2'h1,
        OP_SET    = 2'h2,
        OP_INVERT = 2'h3
    } alias_op_t;

endpackage

`default_nettype wire

// *** verilog/alias_update.sv ***
// Purpose: Computes the new value of one port register for a plain or alias write.
// Assumes: Purely combinational; the caller registers the result.
// Notes:   Bits outside the implemented mask never change.
`default_nettype none
`timescale 1ns/1ps

module alias_update #(
    parameter int WIDTH = 16
) (
    // Operands.
    input  wire logic [WIDTH-1:0]             old_value,
    input  wire logic [WIDTH-1:0]             write_data,
    input  wire logic [WIDTH-1:0]             impl_mask,
    // Operation.
    input  wire gpio_port_pkg::alias_op_t     op,
    // Result.
    output logic      [WIDTH-1:0]             new_value
);

    // ------------------------------------------------------------------
    // Operation select
    // ------------------------------------------------------------------
    // Alias writes only touch bits written as one; unimplemented bits are frozen.
    always_comb begin
        logic [WIDTH-1:0] raw;
        raw = old_value;
        unique case (op)
            gpio_port_pkg::OP_WRITE:  raw = write_data;
            gpio_port_pkg::OP_CLEAR:  raw = old_value & ~write_data;
            gpio_port_pkg::OP_SET:    raw = old_value | write_data;
            gpio_port_pkg::OP_INVERT: raw = old_value ^ write_data;
        endcase
        new_value = (raw & impl_mask) | (old_value & ~impl_mask);
    end

endmodule // alias_update

`default_nettype wire

// *** verilog/gpio_port.sv ***
// Purpose: Parallel I/O port with direction, pin level, latch and open-drain registers on APB.
// Assumes: Pin inputs are synchronous to core_clk; the pad applies out/oe to the wire.
// Notes:   Each register has clear, set and invert aliases for atomic bit updates.
`default_nettype none
`timescale 1ns/1ps

module gpio_port #(
    parameter bit LARGE_VARIANT = 1'b1  // One selects twelve pins, zero six pins.
) (
    // Clock and reset.
    input  wire logic        core_clk,
    input  wire logic        arst_n,
    // APB slave.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [15:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Port pins.
    input  wire logic [15:0] pin_in,
    output logic      [15:0] pin_out,
    output logic      [15:0] pin_oe
);

    // ------------------------------------------------------------------
    // Variant constants
    // ------------------------------------------------------------------
    localparam logic [15:0] IMPL_MASK =
        LARGE_VARIANT ? gpio_port_pkg::LARGE_IMPL_MASK : gpio_port_pkg::SMALL_IMPL_MASK;
    localparam logic [15:0] DIR_RESET =
        LARGE_VARIANT ? gpio_port_pkg::LARGE_DIR_RESET : gpio_port_pkg::SMALL_DIR_RESET;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [15:0] direction;    // One bit per pin, one means input.
        logic [15:0] latch;        // Output latch.
        logic [15:0] open_drain;   // One selects an open-drain driver.
        logic [15:0] sample;       // Registered pin levels.
        logic [31:0] rdata;        // Read data held through the access phase.
        logic        ready;        // Access phase answer.
        logic        slverr;       // Unmapped or misaligned access.
        logic [15:0] drive;        // Pad output value.
        logic [15:0] enable;       // Pad output enable.
    } port_state_t;

    port_state_t state;       // Registered state.
    port_state_t next_state;  // Next state from the combinational process.

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    logic [15:0]              base_addr;  // Address with the alias bits removed.
    gpio_port_pkg::alias_op_t op;         // Alias operation from address bits 3:2.
    logic                     hit_dir;    // Direction register or alias.
    logic                     hit_lvl;    // Pin level register or alias.
    logic                     hit_lat;    // Latch register or alias.
    logic                     hit_odc;    // Open-drain register or alias.
    logic                     mapped;     // Any register hit, word aligned.

    // Aliases share the base's 16-byte slot, so bits 3:2 choose the operation.
    assign base_addr = {paddr[15:4], 4'h0};
    assign op        = gpio_port_pkg::alias_op_t'(paddr[3:2]);
    assign hit_dir   = (base_addr == gpio_port_pkg::PIN_DIRECTION_OFFSET);
    assign hit_lvl   = (base_addr == gpio_port_pkg::PIN_LEVEL_OFFSET);
    assign hit_lat   = (base_addr == gpio_port_pkg::OUTPUT_LATCH_OFFSET);
    assign hit_odc   = (base_addr == gpio_port_pkg::OPEN_DRAIN_SELECT_OFFSET);
    assign mapped    = (hit_dir | hit_lvl | hit_lat | hit_odc) && (paddr[1:0] == 2'h0);

    // ------------------------------------------------------------------
    // Register update values
    // ------------------------------------------------------------------
    logic [15:0] upd_dir;  // Direction after this write.
    logic [15:0] upd_lat;  // Latch after this write.
    logic [15:0] upd_odc;  // Open-drain after this write.

    // One updater per register keeps each alias operation identical for all three.
    alias_update #(.WIDTH(16)) u_dir_update (
        .old_value  (state.direction),
        .write_data (pwdata[15:0]),
        .impl_mask  (IMPL_MASK),
        .op         (op),
        .new_value  (upd_dir)
    );

    alias_update #(.WIDTH(16)) u_lat_update (
        .old_value  (state.latch),
        .write_data (pwdata[15:0]),
        .impl_mask  (IMPL_MASK),
        .op         (op),
        .new_value  (upd_lat)
    );

    alias_update #(.WIDTH(16)) u_odc_update (
        .old_value  (state.open_drain),
        .write_data (pwdata[15:0]),
        .impl_mask  (IMPL_MASK),
        .op         (op),
        .new_value  (upd_odc)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    // The answer is prepared in the setup cycle so pready is high in the
    // first access cycle; the write lands on the edge that completes it.
    always_comb begin
        logic setup;
        logic commit;
        setup  = psel && !penable && !state.ready;
        commit = psel && penable && state.ready;
        next_state = state;

        // Pins are sampled every cycle; unimplemented pins always read zero.
        next_state.sample = pin_in & IMPL_MASK;

        // Setup: latch the read data and answer in the next cycle.
        if (setup) begin
            next_state.ready  = 1'b1;
            next_state.slverr = !mapped;
            next_state.rdata  = 32'h0000_0000;
            if (mapped && op == gpio_port_pkg::OP_WRITE) begin
                // Alias reads answer zero, which is one legal undefined value.
                if (hit_dir) begin
                    next_state.rdata[15:0] = state.direction & IMPL_MASK;
                end else if (hit_lvl) begin
                    next_state.rdata[15:0] = state.sample;
                end else if (hit_lat) begin
                    next_state.rdata[15:0] = state.latch & IMPL_MASK;
                end else begin
                    next_state.rdata[15:0] = state.open_drain & IMPL_MASK;
                end
            end
        end

        // Access completes: apply a write, then drop the answer.
        if (commit) begin
            next_state.ready  = 1'b0;
            next_state.slverr = 1'b0;
            if (pwrite && mapped) begin
                if (hit_dir) begin
                    next_state.direction = upd_dir;
                end
                // Level and latch writes both go to the latch.
                if (hit_lvl || hit_lat) begin
                    next_state.latch = upd_lat;
                end
                if (hit_odc) begin
                    next_state.open_drain = upd_odc;
                end
            end
        end

        // Pad drive: a direction bit of zero makes the pin an output. An
        // open-drain output only pulls low and releases the pin for a one.
        for (int i = 0; i < gpio_port_pkg::PIN_COUNT; i++) begin
            if (!IMPL_MASK[i] || state.direction[i]) begin
                next_state.drive[i]  = 1'b0;
                next_state.enable[i] = 1'b0;
            end else if (state.open_drain[i]) begin
                next_state.drive[i]  = 1'b0;
                next_state.enable[i] = !state.latch[i];
            end else begin
                next_state.drive[i]  = state.latch[i];
                next_state.enable[i] = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    // Latch and sample have no architectural reset value; they clear anyway
    // so simulation never carries unknowns onto the pads.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state.direction  <= DIR_RESET;
            state.latch      <= gpio_port_pkg::LATCH_RESET;
            state.open_drain <= gpio_port_pkg::OPEN_DRAIN_RESET;
            state.sample     <= gpio_port_pkg::SAMPLE_RESET;
            state.rdata      <= 32'h0000_0000;
            state.ready      <= 1'b0;
            state.slverr     <= 1'b0;
            state.drive      <= 16'h0000;
            state.enable     <= 16'h0000;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Every output is a field of the registered state.
    assign prdata  = state.rdata;
    assign pready  = state.ready;
    assign pslverr = state.slverr;
    assign pin_out = state.drive;
    assign pin_oe  = state.enable;

endmodule // gpio_port

`default_nettype wire

// *** dv/gpio_port_props.sv ***
// Purpose: Concurrent checks on the port's APB answers and pad outputs.
// Assumes: Sees only the top module's ports; one clock domain.
// Notes:   Bound to every instance, so each variant is checked with its own mask.
`timescale 1ns/1ps
`default_nettype none

module gpio_port_props #(
    parameter bit LARGE_VARIANT = 1'b1  // Same meaning as in the port.
) (
    // Clock and reset.
    input wire logic        core_clk,
    input wire logic        arst_n,
    // APB.
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Pads.
    input wire logic [15:0] pin_in,
    input wire logic [15:0] pin_out,
    input wire logic [15:0] pin_oe
);
    // Implemented pins of this variant.
    localparam logic [15:0] MASK = LARGE_VARIANT ? gpio_port_pkg::LARGE_IMPL_MASK : gpio_port_pkg::SMALL_IMPL_MASK;
    wire logic setup    = psel && !penable;
    wire logic wdone    = psel && penable && pready && pwrite;
    wire logic bad_addr = paddr < 16'h6180 || paddr > 16'h61bf || paddr[1:0] != 2'h0;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    AST_READY_NEXT: assert property (setup |=> pready) else $error("no ready after setup");
    AST_READY_PULSE: assert property (pready |=> !pready) else $error("ready held");
    AST_UPPER_ZERO: assert property (pready |-> prdata[31:16] == 16'h0000) else $error("upper bits set");
    AST_UNIMPL_READ: assert property (pready |-> (prdata[15:0] & ~MASK) == 16'h0000)
        else $error("unimplemented bit read high");
    AST_UNMAPPED: assert property (setup && bad_addr |=> pslverr && prdata == 32'h0000_0000)
        else $error("unmapped access not refused");
    AST_MAPPED: assert property (setup && !bad_addr |=> !pslverr) else $error("mapped access refused");
    AST_PAD_MASK: assert property (((pin_oe | pin_out) & ~MASK) == 16'h0000) else $error("dead pad driven");
    AST_RESET_INPUT: assert property ($rose(arst_n) |-> pin_oe == 16'h0000) else $error("pad driven at reset");
    AST_DIR_INPUT: assert property (wdone && paddr == gpio_port_pkg::PIN_DIRECTION_OFFSET
        |-> ##2 (pin_oe & $past(pwdata[15:0], 2)) == 16'h0000) else $error("input pin still driven");
    // Only judged while the pins have been steady, so the exact sampling depth does not matter.
    AST_LEVEL_READ: assert property (setup && !pwrite && paddr == gpio_port_pkg::PIN_LEVEL_OFFSET
        && $stable(pin_in) && pin_in == $past(pin_in, 2) && $past(arst_n, 3)
        |=> prdata[15:0] == ($past(pin_in) & MASK)) else $error("level read differs from pins");

    cover property (wdone);
    cover property (setup && bad_addr);
    cover property (pready && !pwrite && !pslverr);
endmodule // gpio_port_props

bind gpio_port gpio_port_props #(.LARGE_VARIANT(LARGE_VARIANT)) gpio_port_props_inst (
    .core_clk(core_clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pready(pready), .pslverr(pslverr), .paddr(paddr), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .pwdata(pwdata), .prdata(prdata));

`default_nettype wire

// *** dv/pin_partner.sv ***
// Purpose: Outside circuitry on the port pins.
// Assumes: Undriven pins follow an outside level, all ones standing for pull-ups.
// Notes:   Open drain low wins over the outside level, as on a real wire.
`timescale 1ns/1ps
`default_nettype none

module pin_partner (
    // Pad side of the port.
    input  wire logic [15:0] pin_out,
    input  wire logic [15:0] pin_oe,
    // Level the outside world puts on pins the port leaves alone.
    input  wire logic [15:0] ext_level,
    // Resolved wire level.
    output logic      [15:0] pin_in
);
    // The wire follows the port where it drives, the outside source elsewhere.
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule // pin_partner

`default_nettype wire

// *** dv/test_io_port_g_registers.sv ***
// Purpose: Self-checking bench for both pin-count variants side by side on one APB.
// Assumes: Both instances answer with the same timing; the bench waits on the large one.
// Notes:   A register model in the bench predicts every read and every pad output.
`timescale 1ns/1ps
`default_nettype none

module test_io_port_g_registers;
    logic        core_clk  = 1'b0;
    logic        arst_n    = 1'b0;
    logic        psel      = 1'b0;
    logic        penable   = 1'b0;
    logic        pwrite    = 1'b0;
    logic [15:0] paddr     = 16'h0000;
    logic [31:0] pwdata    = 32'h0000_0000;
    logic [15:0] ext_level = 16'hffff;
    wire logic [31:0] prdata_v [2];
    wire logic [15:0] pin_in_v [2], pin_out_v [2], pin_oe_v [2];
    wire logic        pready_v [2], pslverr_v [2];
    // Model: index 0 direction, 2 latch, 3 open drain; level writes land on the latch.
    logic [15:0] m [2][4];
    logic [15:0] mask_m [2];
    int          n_mismatch = 0;
    int          comparisons = 0;

    always #4 core_clk = ~core_clk;

    for (genvar v = 0; v < 2; v++) begin : g_var
        gpio_port #(.LARGE_VARIANT(v == 1)) gpio_port_inst (.core_clk(core_clk), .arst_n(arst_n), .psel(psel),
            .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata_v[v]),
            .pready(pready_v[v]), .pslverr(pslverr_v[v]), .pin_in(pin_in_v[v]), .pin_out(pin_out_v[v]),
            .pin_oe(pin_oe_v[v]));
        pin_partner pin_partner_inst (.pin_out(pin_out_v[v]), .pin_oe(pin_oe_v[v]), .ext_level(ext_level),
            .pin_in(pin_in_v[v]));
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer, entered just after a rising edge; one idle cycle follows.
    task automatic apb(input logic [15:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] r [2], output logic e [2]);
        int n;
        n = 0;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready_v[1] !== 1'b1 && n < 20);
        if (n >= 20) begin
            n_mismatch++;
            $display("BAD %0t no ready", $time);
        end
        // The small variant must answer at the same edge as the large one.
        chk(32'(pready_v[0]), 32'h0000_0001);
        r = prdata_v;
        e = pslverr_v;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask

    function automatic logic [15:0] upd(input logic [15:0] o, input logic [15:0] d, input int op);
        case (op)
            1: return o & ~d;
            2: return o | d;
            3: return o ^ d;
            default: return d;
        endcase
    endfunction

    // Reads all four registers back (level last, so the pins have settled) and checks the pads.
    task automatic verify;
        logic [31:0] r [2];
        logic        e [2];
        int          order [4];
        logic [15:0] oe, out, exp;
        order = '{0, 2, 3, 1};
        foreach (order[j]) begin
            apb(gpio_port_pkg::PIN_DIRECTION_OFFSET + 16'(order[j] * 16), 1'b0, 32'h0000_0000, r, e);
            for (int v = 0; v < 2; v++) begin
                oe  = ~m[v][0] & ~(m[v][3] & m[v][2]) & mask_m[v];
                out = ~m[v][0] & ~m[v][3] & m[v][2] & mask_m[v];
                exp = order[j] == 1 ? ((oe & out) | (~oe & ext_level)) & mask_m[v] : m[v][order[j]];
                chk(r[v], {16'h0000, exp});
                chk(32'(e[v]), 32'h0000_0000);
                chk({pin_oe_v[v], pin_out_v[v]}, {oe, out});
            end
        end
    endtask

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        #100000;
        n_mismatch++;
        test_done();
    end

    initial begin
        logic [31:0] r [2];
        logic        e [2];
        logic [15:0] bad [3];
        int          k, op, idx;
        logic [31:0] d;
        void'($urandom(32'hbb4b5ebe));
        bad = '{16'h61c0, 16'h6182, 16'h617c};
        mask_m = '{gpio_port_pkg::SMALL_IMPL_MASK, gpio_port_pkg::LARGE_IMPL_MASK};
        m = '{default: 16'h0000};
        m[0][0] = 16'h03cc;
        m[1][0] = 16'hf3cf;
        repeat (10) @(posedge core_clk);
        arst_n <= 1'b1;
        @(posedge core_clk);
        // Latch and level hold no defined value yet, so only direction and open drain are read first.
        apb(gpio_port_pkg::PIN_DIRECTION_OFFSET, 1'b0, 32'h0000_0000, r, e);
        chk(r[1], 32'h0000_f3cf);
        chk(r[0], 32'h0000_03cc);
        apb(gpio_port_pkg::OPEN_DRAIN_SELECT_OFFSET, 1'b0, 32'h0000_0000, r, e);
        chk(r[1] | r[0], 32'h0000_0000);
        apb(gpio_port_pkg::OUTPUT_LATCH_OFFSET, 1'b1, 32'h0000_0000, r, e);
        // Unmapped and misaligned places refuse both directions and change nothing.
        foreach (bad[j]) begin
            apb(bad[j], 1'b1, 32'hffff_ffff, r, e);
            chk(32'(e[1] & e[0]), 32'h0000_0001);
            apb(bad[j], 1'b0, 32'h0000_0000, r, e);
            // Data and error are checked apart, so neither can hide behind the other.
            chk(r[1] | r[0], 32'h0000_0000);
            chk(32'(e[1] & e[0]), 32'h0000_0001);
        end
        verify();
        // Every register with every operation first, then random mixes.
        for (int i = 0; i < 48; i++) begin
            k  = i < 16 ? i / 4 : $urandom_range(3);
            op = i < 16 ? i % 4 : $urandom_range(3);
            d  = i < 4 ? 32'hffff_ffff : $urandom();
            ext_level <= 16'($urandom());
            apb(gpio_port_pkg::PIN_DIRECTION_OFFSET + 16'(k * 16 + op * 4), 1'b1, d, r, e);
            idx = k == 1 ? 2 : k;
            for (int v = 0; v < 2; v++) m[v][idx] = upd(m[v][idx], d[15:0], op) & mask_m[v];
            verify();
        end
        // Reset again mid-run, with pads likely driven: all pins must fall back to inputs.
        arst_n <= 1'b0;
        repeat (3) @(posedge core_clk);
        arst_n <= 1'b1;
        @(posedge core_clk);
        m[0] = '{16'h03cc, 16'h0000, 16'h0000, 16'h0000};
        m[1] = '{16'hf3cf, 16'h0000, 16'h0000, 16'h0000};
        // The latch has no defined reset content, so it is written before it is read.
        apb(gpio_port_pkg::OUTPUT_LATCH_OFFSET, 1'b1, 32'h0000_0000, r, e);
        verify();
        test_done();
    end
endmodule // test_io_port_g_registers

`default_nettype wire
